// ===== design/hsdo_cfg.svh
// offsets, reset values, field positions and key for the offset calibration bank
`ifndef HSDO_CFG_SVH
`define HSDO_CFG_SVH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define HSDO_ADDR_FRONT_END_CTRL 32'h0000_2000
`define HSDO_ADDR_HS_CONV_CTRL   32'h0000_2010
`define HSDO_ADDR_CAL_KEY        32'h0000_2230
`define HSDO_ADDR_OFFSET_ATTEN   32'h0000_22B8
`define HSDO_ADDR_OFFSET_DIRECT  32'h0000_22BC

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define HSDO_RST_FRONT_END_CTRL  32'h0000_0000
`define HSDO_RST_HS_CONV_CTRL    32'h0000_0000
`define HSDO_RST_CAL_KEY         32'hDE87_A5A0
`define HSDO_RST_OFFSET          12'h000

// ----------------------------------------------------------------------
// key and field positions
// ----------------------------------------------------------------------
`define HSDO_UNLOCK_KEY          32'hDE87_A5AF
`define HSDO_TIA_EN_BIT          11
`define HSDO_ATTEN_BIT           0
`define HSDO_CODE_MSB            11
`define HSDO_CODE_MAX_POS        12'h7FF
`define HSDO_CODE_MAX_NEG        12'h800
`define HSDO_CODE_MINUS_HALF     12'hFFF

`endif

// ===== design/hsdo_pkg.sv
// types shared by the offset calibration bank
package hsdo_pkg;

	// ------------------------------------------------------------------
	// correction code and bus state
	// ------------------------------------------------------------------
	typedef logic [11:0] hsdo_code_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WR   = 3'b010,
		ST_RD   = 3'b100
	} hsdo_state_e;

endpackage

// ===== design/hsdo_select.sv
// picks the offset code that applies to the converter path
`timescale 1ns/10ps
`include "hsdo_cfg.svh"

module hsdo_select (
	input  wire hsdo_pkg::hsdo_code_t code_atten,
	input  wire hsdo_pkg::hsdo_code_t code_direct,
	input  wire logic                 atten_on,
	output hsdo_pkg::hsdo_code_t      code_applied,
	output logic                      code_negative,
	output logic                      code_zero
);

	// ------------------------------------------------------------------
	// path selection
	// ------------------------------------------------------------------
	// attenuator on picks the attenuated code, else the direct one
	always_comb begin
		code_applied = atten_on ? code_atten : code_direct; // RULE7
	end

	// twos complement, half lsb weight: msb gives the sign
	always_comb begin
		code_negative = code_applied[`HSDO_CODE_MSB]; // RULE3
		code_zero     = (code_applied == `HSDO_RST_OFFSET); // RULE3
	end

endmodule

// ===== design/hsdo_regs.sv
// ahb-lite register bank for high speed converter offset calibration
`timescale 1ns/10ps
`include "hsdo_cfg.svh"

// Functional notes
// RULE1: attenuated-path offset register, 12-bit code, resets zero
// RULE2: direct-path offset register, 12-bit code, resets zero
// RULE3: code is twos complement, half-lsb weight
// RULE4: offset writes need unlocked calibration key
// RULE5: amplifier off after reset, on via bit 11
// RULE6: only exact key value unlocks
// RULE7: control bit 0 selects attenuated offset
// RULE8: offset bits 31 to 12 read zero
module hsdo_regs (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             tia_enable,
	output logic      [11:0] offset_applied,
	output logic             offset_negative,
	output logic             offset_zero,
	output logic             atten_active
);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	// word match on the aligned address
	function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] off);
		addr_hit = (a[31:2] == off[31:2]);
	endfunction

	// read mux, unmapped words read as zero
	function automatic logic [31:0] read_word(
		input logic [31:0]          a,
		input logic [31:0]          fe,
		input logic [31:0]          hc,
		input logic [31:0]          key,
		input hsdo_pkg::hsdo_code_t oa,
		input hsdo_pkg::hsdo_code_t od
	);
		read_word = 32'h0000_0000;
		if (addr_hit(a, `HSDO_ADDR_FRONT_END_CTRL)) begin
			read_word = fe;
		end else if (addr_hit(a, `HSDO_ADDR_HS_CONV_CTRL)) begin
			read_word = hc;
		end else if (addr_hit(a, `HSDO_ADDR_CAL_KEY)) begin
			read_word = key;
		end else if (addr_hit(a, `HSDO_ADDR_OFFSET_ATTEN)) begin
			read_word = {20'h00000, oa}; // RULE8
		end else if (addr_hit(a, `HSDO_ADDR_OFFSET_DIRECT)) begin
			read_word = {20'h00000, od}; // RULE8
		end
	endfunction

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	hsdo_pkg::hsdo_state_e state_r;
	hsdo_pkg::hsdo_state_e state_nxt;
	logic [31:0]           addr_r;
	logic [31:0]           addr_nxt;
	logic [31:0]           hrdata_r;
	logic [31:0]           hrdata_nxt;
	logic                  hreadyout_r;
	logic                  hreadyout_nxt;
	logic                  hresp_r;
	logic                  accept;

	logic [31:0]           fe_ctrl_r;
	logic [31:0]           fe_ctrl_nxt;
	logic [31:0]           conv_ctrl_r;
	logic [31:0]           conv_ctrl_nxt;
	logic [31:0]           cal_key_r;
	logic [31:0]           cal_key_nxt;
	hsdo_pkg::hsdo_code_t  off_atten_r;
	hsdo_pkg::hsdo_code_t  off_atten_nxt;
	hsdo_pkg::hsdo_code_t  off_direct_r;
	hsdo_pkg::hsdo_code_t  off_direct_nxt;
	logic                  unlocked;

	hsdo_pkg::hsdo_code_t  sel_code;
	logic                  sel_neg;
	logic                  sel_zero;
	logic                  tia_enable_r;
	hsdo_pkg::hsdo_code_t  applied_r;
	logic                  negative_r;
	logic                  zero_r;
	logic                  atten_r;

	// ------------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------------
	// address phase taken only while the bus is ready
	assign accept = hsel && hready && htrans[1];

	// writes finish with no wait, reads take one wait state so the
	// read sees any write that ended in the same address phase
	always_comb begin
		state_nxt     = hsdo_pkg::ST_IDLE;
		addr_nxt      = addr_r;
		hrdata_nxt    = hrdata_r;
		hreadyout_nxt = 1'b1;
		unique case (state_r)
			hsdo_pkg::ST_RD: begin
				hrdata_nxt = read_word(addr_r, fe_ctrl_r, conv_ctrl_r, cal_key_r,
					off_atten_r, off_direct_r);
			end
			hsdo_pkg::ST_IDLE, hsdo_pkg::ST_WR: begin
				if (accept) begin
					addr_nxt      = haddr;
					state_nxt     = hwrite ? hsdo_pkg::ST_WR : hsdo_pkg::ST_RD;
					hreadyout_nxt = hwrite;
				end
			end
		endcase
	end

	// bus state registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r     <= hsdo_pkg::ST_IDLE;
			addr_r      <= 32'h0000_0000;
			hrdata_r    <= 32'h0000_0000;
			hreadyout_r <= 1'b1;
			hresp_r     <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			addr_r      <= addr_nxt;
			hrdata_r    <= hrdata_nxt;
			hreadyout_r <= hreadyout_nxt;
			hresp_r     <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// register file
	// ------------------------------------------------------------------
	// the lock is the stored key, so a read shows whether it is open
	assign unlocked = (cal_key_r == `HSDO_UNLOCK_KEY); // RULE6

	// write data taken in the data phase; locked offset writes dropped
	always_comb begin
		fe_ctrl_nxt    = fe_ctrl_r;
		conv_ctrl_nxt  = conv_ctrl_r;
		cal_key_nxt    = cal_key_r;
		off_atten_nxt  = off_atten_r;
		off_direct_nxt = off_direct_r;
		if (state_r == hsdo_pkg::ST_WR) begin
			if (addr_hit(addr_r, `HSDO_ADDR_FRONT_END_CTRL)) begin
				fe_ctrl_nxt = hwdata;
			end
			if (addr_hit(addr_r, `HSDO_ADDR_HS_CONV_CTRL)) begin
				conv_ctrl_nxt = hwdata;
			end
			if (addr_hit(addr_r, `HSDO_ADDR_CAL_KEY)) begin
				cal_key_nxt = hwdata; // RULE6
			end
			if (addr_hit(addr_r, `HSDO_ADDR_OFFSET_ATTEN) && unlocked) begin // RULE4
				off_atten_nxt = hwdata[`HSDO_CODE_MSB:0]; // RULE1 RULE8
			end
			if (addr_hit(addr_r, `HSDO_ADDR_OFFSET_DIRECT) && unlocked) begin // RULE4
				off_direct_nxt = hwdata[`HSDO_CODE_MSB:0]; // RULE2 RULE8
			end
		end
	end

	// register file flops, offsets come up at zero correction
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fe_ctrl_r    <= `HSDO_RST_FRONT_END_CTRL; // RULE5
			conv_ctrl_r  <= `HSDO_RST_HS_CONV_CTRL;
			cal_key_r    <= `HSDO_RST_CAL_KEY;
			off_atten_r  <= `HSDO_RST_OFFSET; // RULE1
			off_direct_r <= `HSDO_RST_OFFSET; // RULE2
		end else begin
			fe_ctrl_r    <= fe_ctrl_nxt;
			conv_ctrl_r  <= conv_ctrl_nxt;
			cal_key_r    <= cal_key_nxt;
			off_atten_r  <= off_atten_nxt;
			off_direct_r <= off_direct_nxt;
		end
	end

	// ------------------------------------------------------------------
	// analog side controls
	// ------------------------------------------------------------------
	hsdo_select u_select (
		.code_atten    (off_atten_r),
		.code_direct   (off_direct_r),
		.atten_on      (conv_ctrl_r[`HSDO_ATTEN_BIT]),
		.code_applied  (sel_code),
		.code_negative (sel_neg),
		.code_zero     (sel_zero)
	);

	// one flop stage so every analog control leaves from a register;
	// costs a cycle of latency, harmless for static trims
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tia_enable_r <= 1'b0; // RULE5
			applied_r    <= `HSDO_RST_OFFSET;
			negative_r   <= 1'b0;
			zero_r       <= 1'b1;
			atten_r      <= 1'b0;
		end else begin
			tia_enable_r <= fe_ctrl_r[`HSDO_TIA_EN_BIT]; // RULE5
			applied_r    <= sel_code; // RULE7
			negative_r   <= sel_neg; // RULE3
			zero_r       <= sel_zero; // RULE3
			atten_r      <= conv_ctrl_r[`HSDO_ATTEN_BIT];
		end
	end

	// output drive, all straight from flops
	assign hrdata          = hrdata_r;
	assign hreadyout       = hreadyout_r;
	assign hresp           = hresp_r;
	assign tia_enable      = tia_enable_r;
	assign offset_applied  = applied_r;
	assign offset_negative = negative_r;
	assign offset_zero     = zero_r;
	assign atten_active    = atten_r;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_read_taken;
		accept && !hwrite;
	endsequence

	sequence s_one_wait;
		!hreadyout ##1 hreadyout;
	endsequence

	// a locked offset write leaves the stored code alone
	property p_locked_write_held;
		(state_r == hsdo_pkg::ST_WR) && !unlocked
			&& addr_hit(addr_r, `HSDO_ADDR_OFFSET_ATTEN)
			|=> $stable(off_atten_r);
	endproperty
	a_locked_write_held: assert property (p_locked_write_held) // RULE4
		else $error("attenuated offset changed while locked");

	property p_atten_write;
		(state_r == hsdo_pkg::ST_WR) && unlocked
			&& addr_hit(addr_r, `HSDO_ADDR_OFFSET_ATTEN)
			|=> off_atten_r == $past(hwdata[11:0]);
	endproperty
	a_atten_write: assert property (p_atten_write) // RULE1
		else $error("attenuated offset write lost");

	property p_direct_write;
		(state_r == hsdo_pkg::ST_WR) && unlocked
			&& addr_hit(addr_r, `HSDO_ADDR_OFFSET_DIRECT)
			|=> off_direct_r == $past(hwdata[11:0]);
	endproperty
	a_direct_write: assert property (p_direct_write) // RULE2
		else $error("direct offset write lost");

	property p_direct_locked;
		(state_r == hsdo_pkg::ST_WR) && !unlocked |=> $stable(off_direct_r);
	endproperty
	a_direct_locked: assert property (p_direct_locked) // RULE4
		else $error("direct offset changed while locked");

	// the lock only opens through a key write carrying the exact value
	property p_key_exact;
		$rose(unlocked) |-> ($past(state_r) == hsdo_pkg::ST_WR)
			&& addr_hit($past(addr_r), `HSDO_ADDR_CAL_KEY)
			&& ($past(hwdata) == `HSDO_UNLOCK_KEY);
	endproperty
	a_key_exact: assert property (p_key_exact) // RULE6
		else $error("unlocked with wrong key");

	property p_offset_upper_zero;
		(state_r == hsdo_pkg::ST_RD) && (addr_hit(addr_r, `HSDO_ADDR_OFFSET_ATTEN)
			|| addr_hit(addr_r, `HSDO_ADDR_OFFSET_DIRECT))
			|=> hrdata[31:12] == 20'h00000;
	endproperty
	a_offset_upper_zero: assert property (p_offset_upper_zero) // RULE8
		else $error("offset upper bits not zero");

	property p_tia_follows;
		##1 tia_enable == $past(fe_ctrl_r[11]);
	endproperty
	a_tia_follows: assert property (p_tia_follows) // RULE5
		else $error("amplifier enable does not follow control bit");

	property p_path_select;
		##1 offset_applied == ($past(conv_ctrl_r[0]) ? $past(off_atten_r) : $past(off_direct_r));
	endproperty
	a_path_select: assert property (p_path_select) // RULE7
		else $error("wrong offset path applied");

	property p_sign;
		offset_negative == offset_applied[11] && offset_zero == (offset_applied == 12'h000);
	endproperty
	a_sign: assert property (p_sign) // RULE3
		else $error("offset sign flags inconsistent");

	property p_read_wait;
		s_read_taken |=> s_one_wait;
	endproperty
	a_read_wait: assert property (p_read_wait)
		else $error("read did not take exactly one wait state");

endmodule

// ===== bench/hsdo_tb.sv
// self-checking bench for the offset calibration register bank
`timescale 1ns/10ps
`include "hsdo_cfg.svh"

module testbench;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        tia_enable;
	logic [11:0] offset_applied;
	logic        offset_negative;
	logic        offset_zero;
	logic        atten_active;
	logic [31:0] rd;
	integer      bad_count = 0;
	integer      tests_run = 0;

	// ------------------------------------------------------------------
	// device, clock and reset
	// ------------------------------------------------------------------
	// single slave, so its own ready closes the loop
	hsdo_regs hsdo_regs_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.tia_enable(tia_enable), .offset_applied(offset_applied),
		.offset_negative(offset_negative), .offset_zero(offset_zero),
		.atten_active(atten_active));

	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	// ------------------------------------------------------------------
	// bus tasks and comparison
	// ------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// address phase held until ready, then data phase until ready again
	task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wr ? d : 32'h0000_0000;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
		ahb_xfer(1'b0, a, 32'h0000_0000);
		chk(rd, exp, what);
	endtask

	// outputs lag the registers by one flop, two edges covers it
	task automatic out_chk(input logic [11:0] code, input logic att);
		repeat (2) @(posedge hclk);
		chk({20'h00000, offset_applied}, {20'h00000, code}, "applied code");
		chk({31'h0, offset_negative}, {31'h0, code[11]}, "sign flag");
		chk({31'h0, offset_zero}, {31'h0, code == 12'h000}, "zero flag");
		chk({31'h0, atten_active}, {31'h0, att}, "path flag");
	endtask

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_reset;
		rd_chk(`HSDO_ADDR_OFFSET_ATTEN, 32'h0000_0000, "atten reset");
		rd_chk(`HSDO_ADDR_OFFSET_DIRECT, 32'h0000_0000, "direct reset");
		rd_chk(`HSDO_ADDR_CAL_KEY, `HSDO_RST_CAL_KEY, "key reset");
		chk({31'h0, tia_enable}, 32'h0000_0000, "amp off");
		chk({31'h0, hresp}, 32'h0000_0000, "okay");
		out_chk(12'h000, 1'b0);
		$display("test reset done");
	endtask

	task automatic t_lock;
		ahb_xfer(1'b1, `HSDO_ADDR_OFFSET_ATTEN, 32'h0000_0123);
		rd_chk(`HSDO_ADDR_OFFSET_ATTEN, 32'h0000_0000, "locked write");
		ahb_xfer(1'b1, `HSDO_ADDR_CAL_KEY, 32'hDE87_A5AE);
		ahb_xfer(1'b1, `HSDO_ADDR_OFFSET_DIRECT, 32'h0000_0456);
		rd_chk(`HSDO_ADDR_OFFSET_DIRECT, 32'h0000_0000, "near key");
		ahb_xfer(1'b1, `HSDO_ADDR_CAL_KEY, 32'h5E87_A5AF);
		ahb_xfer(1'b1, `HSDO_ADDR_OFFSET_ATTEN, 32'h0000_0789);
		rd_chk(`HSDO_ADDR_OFFSET_ATTEN, 32'h0000_0000, "top bit key");
		$display("test lock done");
	endtask

	task automatic t_unlock;
		ahb_xfer(1'b1, `HSDO_ADDR_CAL_KEY, `HSDO_UNLOCK_KEY);
		ahb_xfer(1'b1, `HSDO_ADDR_OFFSET_ATTEN, 32'hFFFF_F7FF);
		rd_chk(`HSDO_ADDR_OFFSET_ATTEN, 32'h0000_07FF, "upper bits");
		ahb_xfer(1'b1, `HSDO_ADDR_OFFSET_DIRECT, 32'hABCD_E800);
		rd_chk(`HSDO_ADDR_OFFSET_DIRECT, 32'h0000_0800, "direct write");
		rd_chk(32'h0000_2FF0, 32'h0000_0000, "unmapped");
		$display("test unlock done");
	endtask

	// every documented code through the direct path, then the attenuated path once with its stored 7FF, then back to direct
	task automatic t_codes;
		logic [11:0] codes [5];
		codes = '{12'h7FF, 12'h001, 12'h000, 12'hFFF, 12'h800};
		ahb_xfer(1'b1, `HSDO_ADDR_HS_CONV_CTRL, 32'h0000_0000);
		for (int i = 0; i < 5; i++) begin
			ahb_xfer(1'b1, `HSDO_ADDR_OFFSET_DIRECT, {20'h00000, codes[i]});
			out_chk(codes[i], 1'b0);
		end
		ahb_xfer(1'b1, `HSDO_ADDR_HS_CONV_CTRL, 32'h0000_1001);
		out_chk(12'h7FF, 1'b1);
		ahb_xfer(1'b1, `HSDO_ADDR_HS_CONV_CTRL, 32'h0000_1000);
		out_chk(12'h800, 1'b0);
		$display("test codes done");
	endtask

	task automatic t_relock_amp;
		ahb_xfer(1'b1, `HSDO_ADDR_CAL_KEY, 32'h0000_0000);
		ahb_xfer(1'b1, `HSDO_ADDR_OFFSET_ATTEN, 32'h0000_0001);
		rd_chk(`HSDO_ADDR_OFFSET_ATTEN, 32'h0000_07FF, "relocked");
		ahb_xfer(1'b1, `HSDO_ADDR_FRONT_END_CTRL, 32'hFFFF_F7FF);
		repeat (2) @(posedge hclk);
		chk({31'h0, tia_enable}, 32'h0000_0000, "amp other bits");
		ahb_xfer(1'b1, `HSDO_ADDR_FRONT_END_CTRL, 32'h0000_0800);
		repeat (2) @(posedge hclk);
		chk({31'h0, tia_enable}, 32'h0000_0001, "amp on");
		$display("test relock and amplifier done");
	endtask

	// reset in mid-run, bus idle, must bring every control back to idle
	task automatic t_midreset;
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk({31'h0, tia_enable}, 32'h0000_0000, "amp off again");
		rd_chk(`HSDO_ADDR_CAL_KEY, `HSDO_RST_CAL_KEY, "key relocked");
		rd_chk(`HSDO_ADDR_OFFSET_ATTEN, 32'h0000_0000, "atten cleared");
		rd_chk(`HSDO_ADDR_OFFSET_DIRECT, 32'h0000_0000, "direct cleared");
		out_chk(12'h000, 1'b0);
		$display("test mid-run reset done");
	endtask

	// ------------------------------------------------------------------
	// closing, watchdog and main sequence
	// ------------------------------------------------------------------
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// whole run is just over a hundred cycles, so 20000 means a hang
	initial begin
		#400000;
		bad_count++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		tally_and_finish();
	end

	initial begin
		hresetn <= 1'b0;
		hsel <= 1'b0;
		haddr <= 32'h0000_0000;
		htrans <= 2'b00;
		hwrite <= 1'b0;
		hsize <= 3'b010;
		hwdata <= 32'h0000_0000;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_lock();
		t_unlock();
		t_codes();
		t_relock_amp();
		t_midreset();
		tally_and_finish();
	end
endmodule
